// *** core/nva_pkg.sv ***
package nva_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int MEM_BYTES = 512;
  localparam int PAGE_BYTES = 4;
  localparam int PAGE_W = 2;
  localparam int CNT_W = 20;
  // Device register indices on the I/O port
  localparam logic [1:0] REG_ADDR_LO = 2'h0;
  localparam logic [1:0] REG_ADDR_HI = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h3;
  // Access control bit positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_PAGE = 6;
  localparam int BIT_PM_HI = 5;
  localparam int BIT_PM_LO = 4;
  localparam int BIT_RIE = 3;
  localparam int BIT_ARM = 2;
  localparam int BIT_WSTB = 1;
  localparam int BIT_RSTB = 0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Program action codes
  localparam logic [1:0] PM_ATOMIC = 2'h0;
  localparam logic [1:0] PM_ERASE = 2'h1;
  localparam logic [1:0] PM_WRITE = 2'h2;
  localparam logic [1:0] PM_FLUSH = 2'h3;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int RC_MHZ = 8;
  localparam int RC_WRITE_CYCLES = 26368;
  localparam int T_ATOMIC_CYC = RC_WRITE_CYCLES * CLK_MHZ / RC_MHZ;
  localparam int T_SPLIT_US = 1800;
  localparam int T_SPLIT_CYC = T_SPLIT_US * CLK_MHZ;
  localparam logic [2:0] ARM_CYC = 3'h4;
  localparam logic [2:0] WSTB_STALL = 3'h2;
  localparam logic [2:0] RSTB_STALL = 3'h4;
  localparam logic [2:0] LOAD_CYC = 3'h3;
  // Controller command port
  localparam logic [1:0] HREG_ADDR_LO = 2'h0;
  localparam logic [1:0] HREG_ADDR_HI = 2'h1;
  localparam logic [1:0] HREG_DATA = 2'h2;
  localparam logic [1:0] HREG_CMD = 2'h3;
  localparam int CMD_READ = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_PM_LO = 2;
  localparam int CMD_RIE = 4;
endpackage : nva_pkg

// *** core/nva_if.sv ***
`timescale 1ns/100ps
interface nva_if;
  logic [1:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic stall;
  logic ready_irq;
  logic gie;
  logic spm_busy;
  modport dev (input io_addr, io_wdata, io_wr, io_rd, gie, spm_busy, output io_rdata, stall, ready_irq);
  modport ctl (output io_addr, io_wdata, io_wr, io_rd, gie, spm_busy, input io_rdata, stall, ready_irq);
endinterface : nva_if

// *** core/nva_device.sv ***
// Operation
// R1: 9-bit linear byte address, 0 to 511
// R2: Address bits 15..9 read zero
// R3: Data register feeds writes, receives reads
// R4: Busy flag set during any programming
// R5: Page mode set until program or flush
// R6: Page mode write ignored while strobe set
// R7: Action select picks timed operation or flush
// R8: Action select frozen while strobe set
// R9: Reset clears action select unless busy
// R10: Ready interrupt while enabled and strobe clear
// R11: Arm bit clears four cycles after set
// R12: Strobe starts write only while armed
// R13: Controller polls, arms, strobes within four
// R14: No EEPROM write during flash programming
// R15: Strobe clears itself when write ends
// R16: Strobe write stalls CPU two cycles
// R17: Read strobe loads data, stalls four
// R18: No read or address change while busy
// R19: Write time is 26368 RC cycles
// R20: Controller keeps interrupts off during sequence
// R21: Controller writes address before any access
// R22: Page mode data write loads buffer, three cycles
// R23: Repeated buffer loads store the AND
// R24: Read strobe ignored while writing
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module nva_device #(
  parameter int T_ATOMIC = nva_pkg::T_ATOMIC_CYC, // Erase plus write time in cycles
  parameter int T_SPLIT = nva_pkg::T_SPLIT_CYC    // Erase-only or write-only time in cycles
) (
  input wire logic mclk_in,  // System clock
  input wire logic rst_n_in, // System reset, async, active low
  input wire logic por_n_in, // Power-on reset of the programming engine, active low
  nva_if.dev bus,            // CPU I/O side
  output logic nv_busy_out   // Programming in progress
);
  import nva_pkg::*;

  logic [7:0] mem_ff [MEM_BYTES];
  logic [7:0] pbuf_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pval_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] data_ff;
  logic page_ff;
  logic [1:0] pm_ff;
  logic rie_ff;
  logic arm_ff;
  logic [2:0] arm_cnt_ff;
  logic wstb_ff;
  logic [CNT_W-1:0] prog_cnt_ff;
  logic [2:0] stall_cnt_ff;
  logic stall_ff;
  logic irq_ff;
  logic [7:0] rdata_ff;
  logic busy_ff;
  logic rst_meta_ff;
  logic rst_sync_ff;

  wire [7:0] wd = bus.io_wdata;
  wire wr_lo = bus.io_wr && (bus.io_addr == REG_ADDR_LO);
  wire wr_hi = bus.io_wr && (bus.io_addr == REG_ADDR_HI);
  wire wr_data = bus.io_wr && (bus.io_addr == REG_DATA);
  wire wr_ctrl = bus.io_wr && (bus.io_addr == REG_CTRL);
  wire [1:0] wr_pm = wd[BIT_PM_HI:BIT_PM_LO];
  wire busy_now = wstb_ff || bus.spm_busy; // R4
  wire start_rd = wr_ctrl && wd[BIT_RSTB] && !wstb_ff; // R24 R18
  wire start_wr = wr_ctrl && wd[BIT_WSTB] && arm_ff && !wstb_ff && !bus.spm_busy; // R12 R14
  wire do_flush = start_wr && (wr_pm == PM_FLUSH); // R7
  wire do_prog = start_wr && (wr_pm != PM_FLUSH);
  wire prog_done = wstb_ff && (prog_cnt_ff == '0);
  wire page_load = wr_data && page_ff && !wstb_ff; // R22
  wire [PAGE_W-1:0] pidx = addr_ff[PAGE_W-1:0];
  wire [7:0] ctrl_rd = {busy_now, page_ff, pm_ff, rie_ff, arm_ff, wstb_ff, 1'b0};
  wire [7:0] addr_hi_rd = {7'h00, addr_ff[ADDR_W-1]}; // R2
  wire [7:0] rd_mux = (bus.io_addr == REG_ADDR_LO) ? addr_ff[7:0] :
                      (bus.io_addr == REG_ADDR_HI) ? addr_hi_rd :
                      (bus.io_addr == REG_DATA) ? data_ff : ctrl_rd;
  wire [2:0] nxt_stall_cnt = do_prog || do_flush ? WSTB_STALL : // R16
                             start_rd ? RSTB_STALL :            // R17
                             page_load ? LOAD_CYC - 3'h1 :      // R22
                             (stall_cnt_ff != 3'h0) ? stall_cnt_ff - 3'h1 : 3'h0;

  function automatic logic [7:0] prog_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [1:0] pm);
    case (pm)
      PM_ERASE: prog_byte = ERASED_BYTE;
      PM_WRITE: prog_byte = old_v & new_v;
      default: prog_byte = new_v;
    endcase
  endfunction : prog_byte

  // System reset seen by the engine domain, so a running write keeps its timing and action select; addr_ff and data_ff still reset
  always_ff @(posedge mclk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= rst_n_in;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  always_ff @(posedge mclk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      pm_ff <= PM_ATOMIC;
    end else if (!rst_sync_ff && !wstb_ff) begin
      pm_ff <= PM_ATOMIC; // R9
    end else if (wr_ctrl && !wstb_ff) begin
      pm_ff <= wr_pm; // R8
    end
  end

  // Programming engine
  always_ff @(posedge mclk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      wstb_ff <= 1'b0;
      prog_cnt_ff <= '0;
      page_ff <= 1'b0;
      pval_ff <= '0;
    end else begin
      if (do_prog) begin
        wstb_ff <= 1'b1;
        prog_cnt_ff <= (wr_pm == PM_ATOMIC) ? CNT_W'(T_ATOMIC - 1) : CNT_W'(T_SPLIT - 1); // R7 R19
      end else if (prog_done) begin
        wstb_ff <= 1'b0; // R15
      end else if (wstb_ff) begin
        prog_cnt_ff <= prog_cnt_ff - 1'b1;
      end
      if (prog_done || do_flush) begin
        page_ff <= 1'b0; // R5
        pval_ff <= '0;
      end else begin
        if (wr_ctrl && !wstb_ff && wd[BIT_PAGE]) begin
          page_ff <= 1'b1; // R5 R6
        end
        if (page_load) begin
          pval_ff[pidx] <= 1'b1;
        end
      end
    end
  end

  // Array and page buffer hold content, not control state
  always_ff @(posedge mclk_in) begin
    if (page_load) begin
      pbuf_ff[pidx] <= pval_ff[pidx] ? (pbuf_ff[pidx] & wd) : wd; // R23
    end
    if (prog_done) begin
      if (page_ff) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (pval_ff[i]) begin
            mem_ff[{addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <=
              prog_byte(mem_ff[{addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}], pbuf_ff[i], pm_ff);
          end
        end
      end else begin
        mem_ff[addr_ff] <= prog_byte(mem_ff[addr_ff], data_ff, pm_ff); // R1 R3
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_ff <= '0;
      data_ff <= DATA_RESET;
      rie_ff <= 1'b0;
      arm_ff <= 1'b0;
      arm_cnt_ff <= 3'h0;
    end else begin
      if (wr_lo && !wstb_ff) begin
        addr_ff[7:0] <= wd; // R18
      end
      if (wr_hi && !wstb_ff) begin
        addr_ff[ADDR_W-1] <= wd[0]; // R1 R18
      end
      if (start_rd) begin
        data_ff <= mem_ff[addr_ff]; // R17 R3
      end else if (wr_data) begin
        data_ff <= wd; // R3
      end
      if (wr_ctrl) begin
        rie_ff <= wd[BIT_RIE];
      end
      if (start_wr) begin
        arm_ff <= 1'b0;
      end else if (wr_ctrl && wd[BIT_ARM]) begin
        arm_ff <= 1'b1;
        arm_cnt_ff <= ARM_CYC - 3'h1; // R11
      end else if (arm_ff) begin
        if (arm_cnt_ff == 3'h0) begin
          arm_ff <= 1'b0; // R11
        end else begin
          arm_cnt_ff <= arm_cnt_ff - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stall_cnt_ff <= 3'h0;
      stall_ff <= 1'b0;
      irq_ff <= 1'b0;
      rdata_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else begin
      stall_cnt_ff <= nxt_stall_cnt;
      stall_ff <= (nxt_stall_cnt != 3'h0); // R16 R17
      irq_ff <= rie_ff && bus.gie && !wstb_ff && !bus.spm_busy; // R10
      rdata_ff <= bus.io_rd ? rd_mux : 8'h00;
      busy_ff <= busy_now; // R4
    end
  end

  assign bus.io_rdata = rdata_ff;
  assign bus.stall = stall_ff;
  assign bus.ready_irq = irq_ff;
  assign nv_busy_out = busy_ff;
endmodule : nva_device

// *** core/nva_controller.sv ***
`timescale 1ns/100ps
module nva_controller (
  input wire logic mclk_in,            // System clock
  input wire logic rst_n_in,           // Async reset, active low
  nva_if.ctl bus,                      // Device I/O side
  input wire logic [1:0] cmd_addr_in,  // Command register index
  input wire logic [7:0] cmd_wdata_in, // Command write data
  input wire logic cmd_wr_in,          // Command write strobe
  input wire logic cmd_rd_in,          // Command read strobe
  input wire logic gie_in,             // Global interrupt enable request
  input wire logic spm_busy_in,        // Flash self-programming active
  output logic [7:0] cmd_rdata_out     // Read data, cycle after strobe
);
  import nva_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_POLL_RD = 4'h1, ST_POLL_CHK = 4'h3, ST_ADDR_LO = 4'h2,
    ST_ADDR_HI = 4'h6, ST_DATA = 4'h7, ST_ARM = 4'h5, ST_STROBE = 4'h4,
    ST_RSTB = 4'hC, ST_RDATA = 4'hD, ST_RCAP = 4'hF
  } nva_state_e;

  nva_state_e state_ff;
  nva_state_e nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] data_ff;
  logic [1:0] pm_ff;
  logic rie_ff;
  logic is_wr_ff;
  logic sent_ff;
  logic [1:0] io_addr_ff;
  logic [7:0] io_wdata_ff;
  logic io_wr_ff;
  logic io_rd_ff;
  logic gie_ff;
  logic spm_ff;
  logic [7:0] cmd_rdata_ff;

  wire idle = (state_ff == ST_IDLE);
  wire can_go = !sent_ff && !bus.stall;
  wire rsp_ok = !sent_ff;
  wire hw_busy = bus.io_rdata[BIT_WSTB] || spm_busy_in; // R13 R14
  wire cmd_go = cmd_wr_in && idle && (cmd_addr_in == HREG_CMD) &&
                (cmd_wdata_in[CMD_READ] || cmd_wdata_in[CMD_WRITE]);
  wire [7:0] ctl_base = {2'b00, pm_ff, rie_ff, 3'b000};
  wire issue_wr = can_go && (state_ff == ST_ADDR_LO || state_ff == ST_ADDR_HI || state_ff == ST_DATA ||
                             state_ff == ST_ARM || state_ff == ST_STROBE || state_ff == ST_RSTB);
  wire issue_rd = can_go && (state_ff == ST_POLL_RD || state_ff == ST_RDATA);
  wire [1:0] req_addr = (state_ff == ST_ADDR_LO) ? REG_ADDR_LO :
                        (state_ff == ST_ADDR_HI) ? REG_ADDR_HI :
                        (state_ff == ST_DATA || state_ff == ST_RDATA) ? REG_DATA : REG_CTRL;
  wire [7:0] req_data = (state_ff == ST_ADDR_LO) ? addr_ff[7:0] :
                        (state_ff == ST_ADDR_HI) ? {7'h00, addr_ff[ADDR_W-1]} :
                        (state_ff == ST_DATA) ? data_ff :
                        (state_ff == ST_ARM) ? (ctl_base | 8'h04) :   // R13
                        (state_ff == ST_STROBE) ? (ctl_base | 8'h02) : (ctl_base | 8'h01);
  wire [7:0] stat_rd = {idle ? 1'b0 : 1'b1, bus.ready_irq, 1'b0, rie_ff, pm_ff, 2'b00};
  wire [7:0] cmd_mux = (cmd_addr_in == HREG_ADDR_LO) ? addr_ff[7:0] :
                       (cmd_addr_in == HREG_ADDR_HI) ? {7'h00, addr_ff[ADDR_W-1]} :
                       (cmd_addr_in == HREG_DATA) ? data_ff : stat_rd;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (cmd_go) nxt_state = ST_POLL_RD;
      ST_POLL_RD: if (can_go) nxt_state = ST_POLL_CHK;
      ST_POLL_CHK: if (rsp_ok) nxt_state = hw_busy ? ST_POLL_RD : ST_ADDR_LO;
      ST_ADDR_LO: if (can_go) nxt_state = ST_ADDR_HI; // R21
      ST_ADDR_HI: if (can_go) nxt_state = is_wr_ff ? ST_DATA : ST_RSTB;
      ST_DATA: if (can_go) nxt_state = ST_ARM;
      ST_ARM: if (can_go) nxt_state = ST_STROBE;
      ST_STROBE: if (can_go) nxt_state = ST_IDLE;
      ST_RSTB: if (can_go) nxt_state = ST_RDATA;
      ST_RDATA: if (can_go) nxt_state = ST_RCAP;
      ST_RCAP: if (rsp_ok) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      sent_ff <= 1'b0;
      io_addr_ff <= 2'h0;
      io_wdata_ff <= 8'h00;
      io_wr_ff <= 1'b0;
      io_rd_ff <= 1'b0;
      gie_ff <= 1'b0;
      spm_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sent_ff <= issue_wr || issue_rd;
      io_addr_ff <= req_addr;
      io_wdata_ff <= issue_wr ? req_data : 8'h00;
      io_wr_ff <= issue_wr;
      io_rd_ff <= issue_rd;
      gie_ff <= gie_in && idle && !cmd_go; // R20
      spm_ff <= spm_busy_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_ff <= '0;
      data_ff <= 8'h00;
      pm_ff <= PM_ATOMIC;
      rie_ff <= 1'b0;
      is_wr_ff <= 1'b0;
      cmd_rdata_ff <= 8'h00;
    end else begin
      if (cmd_wr_in && idle && cmd_addr_in == HREG_ADDR_LO) addr_ff[7:0] <= cmd_wdata_in;
      if (cmd_wr_in && idle && cmd_addr_in == HREG_ADDR_HI) addr_ff[ADDR_W-1] <= cmd_wdata_in[0];
      if (cmd_wr_in && idle && cmd_addr_in == HREG_DATA) begin
        data_ff <= cmd_wdata_in;
      end else if (state_ff == ST_RCAP && rsp_ok) begin
        data_ff <= bus.io_rdata;
      end
      if (cmd_go) begin
        is_wr_ff <= cmd_wdata_in[CMD_WRITE];
        pm_ff <= cmd_wdata_in[CMD_PM_LO+1:CMD_PM_LO];
        rie_ff <= cmd_wdata_in[CMD_RIE];
      end
      cmd_rdata_ff <= cmd_rd_in ? cmd_mux : 8'h00;
    end
  end

  assign bus.io_addr = io_addr_ff;
  assign bus.io_wdata = io_wdata_ff;
  assign bus.io_wr = io_wr_ff;
  assign bus.io_rd = io_rd_ff;
  assign bus.gie = gie_ff;
  assign bus.spm_busy = spm_ff;
  assign cmd_rdata_out = cmd_rdata_ff;
endmodule : nva_controller

// *** test/nva_asserts.sv ***
`timescale 1ns/100ps
module nva_asserts
  import nva_pkg::*;
#(
  parameter int T_ATOMIC = 40, // Erase plus write time in cycles
  parameter int T_SPLIT = 20   // Erase-only or write-only time in cycles
) (
  input wire logic mclk_in,        // Clock
  input wire logic rst_n_in,       // Reset, active low
  input wire logic [1:0] io_addr,  // Register index
  input wire logic [7:0] io_wdata, // Write data
  input wire logic io_wr,          // Write strobe
  input wire logic io_rd,          // Read strobe
  input wire logic [7:0] io_rdata, // Read data
  input wire logic stall,          // CPU halt
  input wire logic ready_irq,      // Ready interrupt
  input wire logic gie,            // Global interrupt enable
  input wire logic spm_busy,       // Flash programming busy
  input wire logic nv_busy_out     // Programming in progress
);
  logic [19:0] cnt_ff;
  logic [1:0] pm_ff;
  logic run_ff;
  wire ctrl_wr = io_wr && (io_addr == REG_CTRL);
  wire wstb_wr = ctrl_wr && io_wdata[BIT_WSTB];
  wire arm_wr = ctrl_wr && io_wdata[BIT_ARM] && !io_wdata[BIT_WSTB];
  wire rstb_wr = ctrl_wr && io_wdata[BIT_RSTB] && !nv_busy_out;
  wire addr_wr = io_wr && (io_addr == REG_ADDR_LO || io_addr == REG_ADDR_HI);
  wire timed_wr = wstb_wr && (io_wdata[5:4] != PM_FLUSH) && !spm_busy;
  wire [19:0] exp_len = (pm_ff == PM_ATOMIC) ? 20'(T_ATOMIC) : 20'(T_SPLIT);
  wire len_ok = (cnt_ff + 20'h1 >= exp_len) && (cnt_ff <= exp_len + 20'h1);
  // Length of each busy stretch that a timed write started
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 20'h0;
      pm_ff <= 2'h0;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= wstb_wr ? 20'h0 : (nv_busy_out ? cnt_ff + 20'h1 : 20'h0);
      if (wstb_wr) pm_ff <= io_wdata[5:4];
      if (timed_wr) run_ff <= 1'b1;
      else if (!nv_busy_out && cnt_ff != 20'h0) run_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_one_strobe; !(io_wr && io_rd); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes high");
  property p_arm_strobe; arm_wr |-> ##[1:4] wstb_wr; endproperty
  a_arm_strobe: assert property (p_arm_strobe) else $error("strobe late after arm");
  property p_wstb_stall; wstb_wr && !spm_busy |=> stall [*2] ##1 !stall; endproperty
  a_wstb_stall: assert property (p_wstb_stall) else $error("write stall not two cycles");
  property p_rstb_stall; rstb_wr |=> stall [*4] ##1 !stall; endproperty
  a_rstb_stall: assert property (p_rstb_stall) else $error("read stall not four cycles");
  property p_stall_cause; $rose(stall) |-> $past(io_wr); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without a write");
  property p_busy_start; timed_wr |-> ##[1:3] nv_busy_out; endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy did not rise");
  property p_busy_len; $fell(nv_busy_out) && run_ff |-> len_ok; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time wrong");
  property p_irq_cause; ready_irq |-> $past(gie) && !$past(spm_busy); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("ready interrupt not enabled");
  property p_addr_idle; addr_wr |-> !nv_busy_out; endproperty
  a_addr_idle: assert property (p_addr_idle) else $error("address written while busy");
  property p_gie_off; ctrl_wr && (io_wdata[BIT_ARM] || io_wdata[BIT_WSTB]) |-> !gie; endproperty
  a_gie_off: assert property (p_gie_off) else $error("interrupts on in write sequence");
  property p_rdata_idle; !$past(io_rd) |-> io_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  c_write: cover property (timed_wr);
  c_read: cover property (rstb_wr);
  c_irq: cover property (ready_irq);
endmodule : nva_asserts

// *** test/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import nva_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic por_n = 1'b0;
  logic [1:0] cmd_addr = 2'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic gie_in = 1'b0;
  logic spm_in = 1'b0;
  logic [7:0] cmd_rdata;
  logic nv_busy;
  logic [7:0] r;
  logic [7:0] d;
  logic [8:0] a;
  logic [7:0] ref_b;
  integer seed = 74713;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  nva_if bus ();
  nva_device #(.T_ATOMIC(40), .T_SPLIT(20)) u_nva_device (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .por_n_in(por_n), .bus(bus), .nv_busy_out(nv_busy));
  nva_controller u_nva_controller (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus(bus), .cmd_addr_in(cmd_addr),
    .cmd_wdata_in(cmd_wdata), .cmd_wr_in(cmd_wr), .cmd_rd_in(cmd_rd), .gie_in(gie_in), .spm_busy_in(spm_in),
    .cmd_rdata_out(cmd_rdata));
  nva_asserts #(.T_ATOMIC(40), .T_SPLIT(20)) u_nva_asserts (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .io_addr(bus.io_addr), .io_wdata(bus.io_wdata), .io_wr(bus.io_wr), .io_rd(bus.io_rd),
    .io_rdata(bus.io_rdata), .stall(bus.stall), .ready_irq(bus.ready_irq), .gie(bus.gie),
    .spm_busy(bus.spm_busy), .nv_busy_out(nv_busy));
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  function automatic logic [7:0] exp_byte(input logic [1:0] pm, input logic [7:0] old, input logic [7:0] nw);
    case (pm)
      PM_ATOMIC: return nw;
      PM_ERASE: return ERASED_BYTE;
      PM_WRITE: return old & nw;
      default: return old;
    endcase
  endfunction : exp_byte
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : check
  task automatic do_write(input logic [1:0] ad, input logic [7:0] dt);
    @(posedge mclk_in);
    cmd_addr <= ad;
    cmd_wdata <= dt;
    cmd_wr <= 1'b1;
    @(posedge mclk_in);
    cmd_wr <= 1'b0;
  endtask : do_write
  task automatic do_read(input logic [1:0] ad, output logic [7:0] dt);
    @(posedge mclk_in);
    cmd_addr <= ad;
    cmd_rd <= 1'b1;
    @(posedge mclk_in);
    cmd_rd <= 1'b0;
    @(posedge mclk_in);
    dt = cmd_rdata;
  endtask : do_read
  task automatic wait_idle();
    logic [7:0] s;
    s = 8'hFF;
    for (int i = 0; i < 3000 && s[7] !== 1'b0; i++) do_read(HREG_CMD, s);
    check(s & 8'h80, 8'h00);
  endtask : wait_idle
  // Command byte: bit0 read, bit1 write, bits3:2 action, bit4 ready interrupt enable
  task automatic access(input logic [8:0] ad, input logic [1:0] pm, input logic [7:0] dt, input logic wr,
    input logic rie, input logic wait_done);
    do_write(HREG_ADDR_LO, ad[7:0]);
    do_write(HREG_ADDR_HI, {7'h00, ad[8]});
    do_write(HREG_DATA, dt);
    do_write(HREG_CMD, {3'h0, rie, pm, wr, ~wr});
    if (wait_done) wait_idle();
  endtask : access
  task automatic write_read(input logic [8:0] ad, input logic [1:0] pm, input logic [7:0] dt,
    input logic [7:0] exp);
    logic [7:0] got;
    access(ad, pm, dt, 1'b1, 1'b0, 1'b1);
    access(ad, PM_ATOMIC, 8'h00, 1'b0, 1'b0, 1'b1);
    do_read(HREG_DATA, got);
    check(got, exp);
  endtask : write_read
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    por_n <= 1'b1;
    // Corner addresses first, then random ones
    for (int i = 0; i < 20; i++) begin
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
      d = 8'($random(seed));
      write_read(a, PM_ATOMIC, d, d);
    end
    // Every action code on one byte
    ref_b = 8'h5A;
    write_read(9'h123, PM_ATOMIC, ref_b, ref_b);
    for (int pm = 1; pm < 4; pm++) begin
      d = 8'($random(seed));
      ref_b = exp_byte(2'(pm), ref_b, d);
      write_read(9'h123, 2'(pm), d, ref_b);
    end
    write_read(9'h123, PM_ERASE, 8'h00, ERASED_BYTE);
    write_read(9'h123, PM_WRITE, 8'h3C, 8'h3C & ERASED_BYTE);
    // Ready interrupt: enabled, then blocked by flash programming
    gie_in <= 1'b1;
    access(9'h010, PM_ATOMIC, 8'h00, 1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge mclk_in);
    do_read(HREG_CMD, r);
    check({7'h00, r[6]}, 8'h01);
    spm_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    do_read(HREG_CMD, r);
    check({6'h00, nv_busy, r[6]}, 8'h02);
    // Write held off while flash programming runs
    access(9'h0AA, PM_ATOMIC, 8'hC3, 1'b1, 1'b0, 1'b0);
    repeat (60) @(posedge mclk_in);
    do_read(HREG_CMD, r);
    check({7'h00, r[7]}, 8'h01);
    spm_in <= 1'b0;
    gie_in <= 1'b0;
    wait_idle();
    access(9'h0AA, PM_ATOMIC, 8'h00, 1'b0, 1'b0, 1'b1);
    do_read(HREG_DATA, r);
    check(r, 8'hC3);
    // System reset during an erase: the action select must survive it
    access(9'h000, PM_ERASE, 8'h00, 1'b1, 1'b1, 1'b1);
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    do_read(HREG_CMD, r);
    check(r, 8'h00);
    access(9'h000, PM_ATOMIC, 8'h00, 1'b0, 1'b0, 1'b1);
    do_read(HREG_DATA, r);
    check(r, ERASED_BYTE);
    print_verdict();
  end
endmodule : tb_top
